// ==== rtl/serial_port_defines.vh ====
`ifndef SERIAL_PORT_DEFINES_VH
`define SERIAL_PORT_DEFINES_VH

// register indices on the processor register port
`define REG_CONTROL_ONE   3'h0
`define REG_CONTROL_TWO   3'h1
`define REG_RATE_SELECT   3'h2
`define REG_STATUS        3'h3
`define REG_SHIFT_DATA    3'h5
`define REG_PORT_DATA     3'h6
`define REG_PORT_DIR      3'h7

// control one fields
`define C1_IRQ_ENABLE     7
`define C1_SYSTEM_ENABLE  6
`define C1_OPEN_DRAIN     5
`define C1_MASTER_SELECT  4
`define C1_CLOCK_POLARITY 3
`define C1_CLOCK_PHASE    2
`define C1_SELECT_OUT_EN  1
`define C1_LOW_BIT_FIRST  0

// control two fields
`define C2_PULLUP_ENABLE  3
`define C2_REDUCED_DRIVE  2
`define C2_PIN_CONFIG     0
`define C2_WRITE_MASK     8'h0d

// status fields
`define ST_TRANSFER_DONE  7
`define ST_WRITE_COLL     6
`define ST_MODE_FAULT     4

// port bit positions inside the four-pin group
`define PIN_MISO          0
`define PIN_MOSI          1
`define PIN_SCK           2
`define PIN_SELECT        3

// reset values
`define RST_CONTROL_ONE   8'h04
`define RST_CONTROL_TWO   8'h00
`define RST_RATE_SELECT   3'h0
`define RST_PORT_DIR      4'h0
`define RST_PORT_DATA     4'h0

// index of the last of the 16 serial clock edges of a byte
`define LAST_EDGE         4'hf

`endif

// ==== rtl/rate_divider.v ====
`timescale 1ns/1ns
`default_nettype none

module rate_divider (
  input  wire       clk,
  input  wire       reset_n,
  input  wire       run,
  input  wire [2:0] rate,
  output reg        tick
);

  reg  [6:0] count;
  wire [6:0] limit;

  // half a serial clock period, in processor clocks, minus one
  function [6:0] half_limit;
    input [2:0] r;
    begin
      half_limit = 7'h7f >> (3'h7 - r);
    end
  endfunction

  assign limit = half_limit(rate);

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      count <= 7'h00;
      tick  <= 1'b0;
    end else if (!run) begin
      count <= 7'h00;
      tick  <= 1'b0;
    end else if (count >= limit) begin
      count <= 7'h00;
      tick  <= 1'b1;
    end else begin
      count <= count + 7'h01;
      tick  <= 1'b0;
    end
  end

endmodule // rate_divider

`default_nettype wire

// ==== rtl/shift_ring.v ====
`timescale 1ns/1ns
`default_nettype none

module shift_ring #(
  parameter WIDTH = 8
) (
  input  wire             clk,
  input  wire             reset_n,
  input  wire             clear,
  input  wire             load,
  input  wire [WIDTH-1:0] load_data,
  input  wire             sample,
  input  wire             shift,
  input  wire             low_bit_first,
  input  wire             serial_in,
  output reg  [WIDTH-1:0] data,
  output wire             serial_out
);

  reg  held_bit;
  wire in_bit;

  // a shift that coincides with a sample takes the live input
  assign in_bit     = sample ? serial_in : held_bit;
  assign serial_out = low_bit_first ? data[0] : data[WIDTH-1];

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      data     <= {WIDTH{1'b0}};
      held_bit <= 1'b0;
    end else begin
      if (clear) begin
        held_bit <= 1'b0;
      end else if (sample) begin
        held_bit <= serial_in;
      end
      if (load) begin
        data <= load_data;
      end else if (shift) begin
        if (low_bit_first) begin
          data <= {in_bit, data[WIDTH-1:1]};
        end else begin
          data <= {data[WIDTH-2:0], in_bit};
        end
      end
    end
  end

endmodule // shift_ring

`default_nettype wire

// ==== rtl/sync_serial_master_slave_port.v ====
`timescale 1ns/1ns
`default_nettype none
`include "serial_port_defines.vh"

module sync_serial_master_slave_port (
  input  wire       clk,
  input  wire       reset_n,
  input  wire [2:0] reg_addr,
  input  wire       reg_write,
  input  wire       reg_read,
  input  wire [7:0] reg_wdata,
  output reg  [7:0] reg_rdata,
  output wire       irq,
  input  wire [3:0] pin_in,
  output reg  [3:0] pin_out,
  output reg  [3:0] pin_oe,
  output wire [3:0] pin_pullup,
  output wire       reduced_drive
);

  reg  [7:0] control_one;
  reg  [7:0] control_two;
  reg  [2:0] rate_select;
  reg  [3:0] port_dir;
  reg  [3:0] port_data;
  reg  [7:0] read_buffer;
  reg        transfer_done_flag;
  reg        write_collision_flag;
  reg        mode_fault_flag;
  reg        done_armed;
  reg        coll_armed;
  reg        fault_armed;
  reg        master_busy;
  reg        sck_level;
  reg        sck_prev;
  reg  [3:0] edge_count;
  reg        finish;
  reg        finish_q;
  reg  [3:0] drive_val;
  reg  [3:0] drive_en;
  reg  [7:0] next_rdata;

  wire       tick;
  wire [7:0] ring_data;
  wire       ring_out;

  wire irq_enable           = control_one[`C1_IRQ_ENABLE];
  wire system_enable        = control_one[`C1_SYSTEM_ENABLE] & ~mode_fault_flag;
  wire open_drain_select    = control_one[`C1_OPEN_DRAIN];
  wire master_select        = control_one[`C1_MASTER_SELECT];
  wire clock_polarity       = control_one[`C1_CLOCK_POLARITY];
  wire clock_phase          = control_one[`C1_CLOCK_PHASE];
  wire select_output_enable = control_one[`C1_SELECT_OUT_EN];
  wire low_bit_first        = control_one[`C1_LOW_BIT_FIRST];
  wire pin_config_bit       = control_two[`C2_PIN_CONFIG];
  wire pullup_enable        = control_two[`C2_PULLUP_ENABLE];
  wire select_pin_direction = port_dir[`PIN_SELECT];

  wire is_master = system_enable & master_select;
  wire is_slave  = system_enable & ~master_select;
  wire select_in = pin_in[`PIN_SELECT];
  wire sck_in    = pin_in[`PIN_SCK];

  // register port decode
  wire wr_ctrl1  = reg_write & (reg_addr == `REG_CONTROL_ONE);
  wire wr_ctrl2  = reg_write & (reg_addr == `REG_CONTROL_TWO);
  wire wr_rate   = reg_write & (reg_addr == `REG_RATE_SELECT);
  wire wr_data   = reg_write & (reg_addr == `REG_SHIFT_DATA);
  wire wr_port   = reg_write & (reg_addr == `REG_PORT_DATA);
  wire wr_dir    = reg_write & (reg_addr == `REG_PORT_DIR);
  wire rd_status = reg_read & (reg_addr == `REG_STATUS);
  wire data_acc  = (reg_read | reg_write) & (reg_addr == `REG_SHIFT_DATA);

  // slave transfer is live while selected
  wire slave_active = is_slave & ~select_in;
  // the byte still settles in the two clocks after the last serial edge
  wire busy         = master_busy | slave_active | finish | finish_q;
  wire start        = wr_data & ~busy & is_master;

  // a serial clock edge: generated as master, observed as slave
  wire slave_edge = slave_active & (sck_in != sck_prev);
  wire serial_edge = (master_busy & tick) | slave_edge;
  wire sample_edge = serial_edge & (edge_count[0] == clock_phase);
  // in phase 1 the last sample edge only captures; the ring moves one clock later,
  // so the outgoing bit still stands while the partner samples it
  wire shift_edge  = (serial_edge & (clock_phase ?
                     (~edge_count[0] & (edge_count != 4'h0)) :
                     edge_count[0])) | (finish & clock_phase);
  wire last_edge   = serial_edge & (edge_count == `LAST_EDGE);

  // the fault only watches a select pin dedicated as input
  wire fault_event = is_master & ~select_pin_direction & ~select_in;

  wire serial_in = master_select ? (pin_config_bit ? pin_in[`PIN_MOSI] : pin_in[`PIN_MISO]) :
                                   (pin_config_bit ? pin_in[`PIN_MISO] : pin_in[`PIN_MOSI]);

  rate_divider u_rate_divider (
    .clk     (clk),
    .reset_n (reset_n),
    .run     (master_busy),
    .rate    (rate_select),
    .tick    (tick)
  );

  shift_ring #(
    .WIDTH (8)
  ) u_shift_ring (
    .clk           (clk),
    .reset_n       (reset_n),
    .clear         (~system_enable),
    .load          (wr_data & ~busy),
    .load_data     (reg_wdata),
    .sample        (sample_edge),
    .shift         (shift_edge),
    .low_bit_first (low_bit_first),
    .serial_in     (serial_in),
    .data          (ring_data),
    .serial_out    (ring_out)
  );

  // configuration registers
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      control_one <= `RST_CONTROL_ONE;
      control_two <= `RST_CONTROL_TWO;
      rate_select <= `RST_RATE_SELECT;
      port_dir    <= `RST_PORT_DIR;
      port_data   <= `RST_PORT_DATA;
    end else begin
      if (wr_ctrl1) begin
        control_one <= reg_wdata;
      end
      if (wr_ctrl2) begin
        control_two <= reg_wdata & `C2_WRITE_MASK;
      end
      if (wr_rate) begin
        rate_select <= reg_wdata[2:0];
      end
      if (wr_dir) begin
        port_dir <= reg_wdata[7:4];
      end
      if (wr_port) begin
        port_data <= reg_wdata[7:4];
      end
    end
  end

  // transfer sequencing
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      master_busy <= 1'b0;
      sck_level   <= 1'b0;
      sck_prev    <= 1'b0;
      edge_count  <= 4'h0;
      finish      <= 1'b0;
      finish_q    <= 1'b0;
      read_buffer <= 8'h00;
    end else begin
      sck_prev <= sck_in;
      finish   <= last_edge;
      finish_q <= finish;
      // taken after the delayed phase 1 shift has landed
      if (finish_q) begin
        read_buffer <= ring_data;
      end
      if (!system_enable) begin
        master_busy <= 1'b0;
        sck_level   <= clock_polarity;
        edge_count  <= 4'h0;
      end else if (start) begin
        master_busy <= 1'b1;
        sck_level   <= clock_polarity;
        edge_count  <= 4'h0;
      end else if (master_busy) begin
        if (tick) begin
          sck_level  <= ~sck_level;
          edge_count <= edge_count + 4'h1;
          if (last_edge) begin
            master_busy <= 1'b0;
          end
        end
      end else if (is_slave) begin
        sck_level <= clock_polarity;
        if (select_in) begin
          edge_count <= 4'h0;
        end else if (slave_edge) begin
          edge_count <= edge_count + 4'h1;
        end
      end else begin
        sck_level <= clock_polarity;
      end
    end
  end

  // status flags: setting wins over a clear in the same cycle
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      transfer_done_flag   <= 1'b0;
      write_collision_flag <= 1'b0;
      mode_fault_flag      <= 1'b0;
      done_armed           <= 1'b0;
      coll_armed           <= 1'b0;
      fault_armed          <= 1'b0;
    end else begin
      if (rd_status) begin
        done_armed  <= transfer_done_flag;
        coll_armed  <= write_collision_flag;
        fault_armed <= mode_fault_flag;
      end
      if (finish_q) begin
        transfer_done_flag <= 1'b1;
      end else if (data_acc & done_armed) begin
        transfer_done_flag <= 1'b0;
        done_armed         <= 1'b0;
      end
      if (wr_data & busy) begin
        write_collision_flag <= 1'b1;
      end else if (data_acc & coll_armed) begin
        write_collision_flag <= 1'b0;
        coll_armed           <= 1'b0;
      end
      if (fault_event) begin
        mode_fault_flag <= 1'b1;
      end else if (wr_ctrl1 & fault_armed) begin
        mode_fault_flag <= 1'b0;
        fault_armed     <= 1'b0;
      end
    end
  end

  assign irq = irq_enable & (transfer_done_flag | mode_fault_flag);

  // register read data
  always @* begin
    next_rdata = 8'h00;
    case (reg_addr)
      `REG_CONTROL_ONE: begin
        next_rdata = control_one;
        next_rdata[`C1_SYSTEM_ENABLE] = system_enable;
      end
      `REG_CONTROL_TWO: begin
        next_rdata = control_two;
      end
      `REG_RATE_SELECT: begin
        next_rdata = {5'h00, rate_select};
      end
      `REG_STATUS: begin
        next_rdata[`ST_TRANSFER_DONE] = transfer_done_flag;
        next_rdata[`ST_WRITE_COLL]    = write_collision_flag;
        next_rdata[`ST_MODE_FAULT]    = mode_fault_flag;
      end
      `REG_SHIFT_DATA: begin
        next_rdata = read_buffer;
      end
      `REG_PORT_DATA: begin
        next_rdata = {pin_in, 4'h0};
      end
      `REG_PORT_DIR: begin
        next_rdata = {port_dir, 4'h0};
      end
      default: begin
        next_rdata = 8'h00;
      end
    endcase
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_read) begin
      reg_rdata <= next_rdata;
    end
  end

  // pin roles: general purpose unless the serial function claims a pin
  always @* begin
    drive_val = port_data;
    drive_en  = port_dir;
    if (system_enable) begin
      if (master_select) begin
        drive_val[`PIN_SCK] = sck_level;
        drive_en[`PIN_SCK]  = port_dir[`PIN_SCK];
        drive_val[`PIN_MOSI] = ring_out;
        drive_en[`PIN_MOSI]  = port_dir[`PIN_MOSI];
        if (!pin_config_bit) begin
          drive_en[`PIN_MISO] = 1'b0;
        end
        if (select_pin_direction & select_output_enable) begin
          // held low one clock past the last edge so the slave still sees it selected
          drive_val[`PIN_SELECT] = ~(master_busy | finish);
          drive_en[`PIN_SELECT]  = 1'b1;
        end else if (!select_pin_direction) begin
          drive_en[`PIN_SELECT] = 1'b0;
        end
      end else begin
        drive_en[`PIN_SCK]    = 1'b0;
        drive_en[`PIN_SELECT] = 1'b0;
        drive_val[`PIN_MISO]  = ring_out;
        drive_en[`PIN_MISO]   = port_dir[`PIN_MISO] & ~select_in;
        if (!pin_config_bit) begin
          drive_en[`PIN_MOSI] = 1'b0;
        end
      end
    end
  end

  // wired-or: a driven high is released to the pull-up instead
  always @* begin
    pin_out = drive_val;
    pin_oe  = drive_en & ~({4{open_drain_select}} & drive_val);
  end

  assign pin_pullup    = {4{pullup_enable}} & ~drive_en;
  assign reduced_drive = control_two[`C2_REDUCED_DRIVE];

  // bidirectional mode reads the shared pin back through serial_in
  // and leaves the other data pin to general purpose use

endmodule // sync_serial_master_slave_port

`default_nettype wire

// ==== testbench/port_props.sv ====
`timescale 1ns/1ns
`default_nettype none
module port_props (
  input wire logic       clk,
  input wire logic       reset_n,
  input wire logic [2:0] reg_addr,
  input wire logic       reg_write,
  input wire logic [7:0] reg_wdata,
  input wire logic       irq,
  input wire logic [3:0] pin_in,
  input wire logic [3:0] pin_out,
  input wire logic [3:0] pin_oe
);
  logic [7:0] c1;
  logic [7:0] dir;
  logic [2:0] rate;
  logic [8:0] cnt;
  logic [3:0] tog;
  logic       sck_q;
  logic [1:0] cfg_q;
  // a sck change right after a config write is not a serial edge
  wire flip = pin_oe[2] && sck_q != pin_out[2] && !cfg_q[1];
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      c1 <= 8'h04;
      dir <= 8'h00;
      rate <= 3'h0;
      cnt <= 9'h000;
      tog <= 4'h0;
      sck_q <= 1'b0;
      cfg_q <= 2'h0;
    end else begin
      if (reg_write && reg_addr == 3'h0) c1 <= reg_wdata;
      if (reg_write && reg_addr == 3'h7) dir <= reg_wdata;
      if (reg_write && reg_addr == 3'h2) rate <= reg_wdata[2:0];
      cnt <= flip ? 9'h000 : cnt + 9'h001;
      tog <= flip ? tog + 4'h1 : tog;
      sck_q <= pin_out[2];
      cfg_q <= {cfg_q[0], reg_write && (reg_addr == 3'h0 || reg_addr == 3'h7)};
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence s_last;
    flip && tog == 4'hf;
  endsequence
  property p_rate; flip && tog != 4'h0 |-> cnt == (9'h001 << rate) - 9'h001; endproperty
  property p_idle;
    c1[6] && c1[4] && pin_oe[2] && tog == 4'h0 && !flip && !cfg_q[0] |-> pin_out[2] == c1[3];
  endproperty
  property p_sel; tog != 4'h0 && pin_oe[3] |-> !pin_out[3]; endproperty
  property p_done; c1[7] ##0 s_last |-> ##[1:4] irq; endproperty
  property p_irq_off; reg_write && reg_addr == 3'h0 && !reg_wdata[7] |=> !irq; endproperty
  property p_fault; c1[7] && c1[6] && c1[4] && !dir[7] && !pin_in[3] |-> ##[0:2] irq; endproperty
  property p_slv_oe; c1[6] && !c1[4] && (!dir[4] || pin_in[3] && $past(pin_in[3])) |-> !pin_oe[0]; endproperty
  property p_mst_oe; c1[6] && c1[4] && !dir[5] |-> !pin_oe[1]; endproperty
  a_rate: assert property (p_rate) else $error("sck half period wrong");
  a_idle: assert property (p_idle) else $error("sck idle level wrong");
  a_sel: assert property (p_sel) else $error("select high in transfer");
  a_done: assert property (p_done) else $error("no irq after last edge");
  a_irq_off: assert property (p_irq_off) else $error("irq not masked");
  a_fault: assert property (p_fault) else $error("fault not flagged");
  a_slv_oe: assert property (p_slv_oe) else $error("slave out driven");
  a_mst_oe: assert property (p_mst_oe) else $error("master out driven");
endmodule // port_props
bind sync_serial_master_slave_port port_props u_props (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
  .reg_write(reg_write), .reg_wdata(reg_wdata), .irq(irq), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe));
`default_nettype wire

// ==== testbench/slave_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module slave_model (
  input  wire logic       sck,
  input  wire logic       mosi,
  input  wire logic       sel_n,
  input  wire logic [2:0] fmt,
  input  wire logic [7:0] tx,
  output var  logic       miso,
  output var  logic [7:0] rx
);
  int no;
  int ni;
  // fmt is {low_bit_first, polarity, phase}
  function automatic logic bit_at(input int i);
    return fmt[2] ? tx[i] : tx[7-i];
  endfunction
  initial miso = 1'b0;
  always @(negedge sel_n) begin
    ni = 0;
    no = 0;
    if (!fmt[0]) begin
      miso = bit_at(0);
      no = 1;
    end
  end
  always @(sck) begin
    if (!sel_n) begin
      if ((sck != fmt[1]) ^ fmt[0]) begin
        rx[fmt[2] ? ni : 7 - ni] = mosi;
        ni++;
      end else if (no < 8) begin
        miso = bit_at(no);
        no++;
      end
    end
  end
  // released line: show the inverse of the last bit
  always @(posedge sel_n) miso = ~miso;
endmodule // slave_model
`default_nettype wire

// ==== testbench/tb_top.sv ====
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic       clk;
  logic       reset_n;
  logic [2:0] reg_addr;
  logic       reg_write;
  logic       reg_read;
  logic [7:0] reg_wdata;
  wire  [7:0] reg_rdata;
  wire        irq;
  wire  [3:0] pin_in;
  wire  [3:0] pin_out;
  wire  [3:0] pin_oe;
  wire  [3:0] pin_pullup;
  wire        reduced_drive;
  wire        miso;
  wire  [7:0] srx;
  logic       ext_sel_n;
  logic [2:0] fmt;
  logic [7:0] stx;
  logic [7:0] tx;
  logic [7:0] d;
  int         fails;
  int         n_compared;
  int         cyc = 0;
  assign pin_in[0] = pin_oe[0] ? pin_out[0] : miso;
  assign pin_in[1] = pin_oe[1] ? pin_out[1] : ~pin_out[1];
  assign pin_in[2] = pin_oe[2] ? pin_out[2] : fmt[1];
  assign pin_in[3] = pin_oe[3] ? pin_out[3] : ext_sel_n;
  sync_serial_master_slave_port u_dut (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_write(reg_write),
    .reg_read(reg_read), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .irq(irq), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup(pin_pullup), .reduced_drive(reduced_drive));
  slave_model u_slave (.sck(pin_in[2]), .mosi(pin_in[1]), .sel_n(pin_in[3]), .fmt(fmt), .tx(stx),
    .miso(miso), .rx(srx));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge clk);
    #1;
    reg_addr = a;
    reg_wdata = v;
    reg_write = 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] v);
    @(posedge clk);
    #1;
    reg_addr = a;
    reg_read = 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    #1;
    v = reg_rdata;
  endtask
  task automatic wait_done;
    int k;
    k = 0;
    d = 8'h00;
    while (d[7] !== 1'b1 && k < 5000) begin
      rd(3'h3, d);
      k++;
    end
  endtask
  task automatic final_report;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      $display("MISMATCH t=%0t timeout", $time);
      final_report;
    end
  end
  initial begin
    reset_n = 1'b0;
    reg_addr = 3'h0;
    reg_write = 1'b0;
    reg_read = 1'b0;
    reg_wdata = 8'h00;
    ext_sel_n = 1'b1;
    fmt = 3'h1;
    stx = 8'h00;
    fails = 0;
    n_compared = 0;
    repeat (3) @(posedge clk);
    #1 reset_n = 1'b1;
    rd(3'h0, d);
    chk(d, 8'h04);
    rd(3'h2, d);
    chk(d, 8'h00);
    rd(3'h4, d);
    chk(d, 8'h00);
    wr(3'h1, 8'hff);
    rd(3'h1, d);
    chk(d, 8'h0d);
    chk({4'h0, pin_pullup}, 8'h0f);
    chk({7'h0, reduced_drive}, 8'h01);
    wr(3'h1, 8'h08);
    wr(3'h0, 8'h50);
    wr(3'h7, 8'he0);
    for (int i = 0; i < 8; i++) begin
      fmt = i[2:0];
      tx = 8'h81 ^ {i[2:0], i[2:0], 2'h0};
      stx = 8'h5a ^ {2'h0, i[2:0], i[2:0]};
      wr(3'h2, {5'h00, i[2:0]});
      wr(3'h0, {i[0], 3'b101, i[1], i[0], 1'b1, i[2]});
      wr(3'h5, tx);
      wait_done;
      chk(d, 8'h80);
      chk({7'h0, irq}, {7'h0, i[0]});
      rd(3'h5, d);
      chk(d, stx);
      chk(srx, tx);
      rd(3'h3, d);
      chk(d, 8'h00);
    end
    wr(3'h2, 8'h00);
    wr(3'h0, 8'h52);
    fmt = 3'h0;
    stx = 8'hc3;
    wr(3'h5, 8'h3c);
    wr(3'h5, 8'hff);
    wait_done;
    chk(d, 8'hc0);
    rd(3'h5, d);
    chk(d, 8'hc3);
    chk(srx, 8'h3c);
    rd(3'h3, d);
    chk(d, 8'h00);
    chk({4'h0, pin_pullup}, 8'h01);
    wr(3'h0, 8'h72);
    #1;
    chk({7'h0, pin_oe[3]}, 8'h00);
    wr(3'h7, 8'h60);
    wr(3'h0, 8'hd0);
    #1 ext_sel_n = 1'b0;
    rd(3'h3, d);
    chk(d, 8'h10);
    chk({7'h0, irq}, 8'h01);
    rd(3'h0, d);
    chk(d, 8'h90);
    ext_sel_n = 1'b1;
    rd(3'h3, d);
    wr(3'h0, 8'h50);
    rd(3'h3, d);
    chk(d, 8'h00);
    wr(3'h0, 8'h44);
    wr(3'h7, 8'h10);
    #1;
    chk({7'h0, pin_oe[0]}, 8'h00);
    ext_sel_n = 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk({7'h0, pin_oe[0]}, 8'h01);
    wr(3'h7, 8'h00);
    #1;
    chk({7'h0, pin_oe[0]}, 8'h00);
    ext_sel_n = 1'b1;
    wr(3'h1, 8'h01);
    wr(3'h7, 8'h40);
    wr(3'h0, 8'h50);
    #1;
    chk({7'h0, pin_oe[1]}, 8'h00);
    wr(3'h5, 8'h3c);
    wait_done;
    chk(d, 8'h80);
    rd(3'h5, d);
    chk(d, 8'hc3);
    final_report;
  end
endmodule // tb_top
`default_nettype wire
